// ---- nand_status_defs.svh ----
`ifndef NAND_STATUS_DEFS_SVH
`define NAND_STATUS_DEFS_SVH

// ----------------------------------------------------------------
// Serial command and feature address codes
// ----------------------------------------------------------------
`define CMD_GET_FEATURE 8'h0f
`define CMD_SET_FEATURE 8'h1f
`define CMD_WRITE_LOCK  8'h04
`define FEAT_STATUS     8'hc0
`define FEAT_CONFIG     8'hb0

// ----------------------------------------------------------------
// Field codes, reset values and bit counts
// ----------------------------------------------------------------
`define ECC_CLEAN       2'h0
`define ECC_FIXED       2'h1
`define ECC_LOST        2'h2
`define ECC_RSVD        2'h3
`define STATUS_RST      8'h00
`define ECC_EN_RST      1'b1
`define BIT_LAST        3'h7
`define BIT_FIRST       3'h0
`define CFG_ECC_SLOT    3'h3

`endif

// ---- nand_status_pkg.sv ----
package nand_status_pkg;

   // ----------------------------------------------------------------
   // Status byte, most significant field first
   // ----------------------------------------------------------------
   typedef struct packed {
      logic reserved;
      logic cache_transfer_busy_flag;
      logic correction_result_high;
      logic correction_result_low;
      logic program_failure_flag;
      logic erase_failure_flag;
      logic write_latch_flag;
      logic operation_active_flag;
   } device_status_s;

   // ----------------------------------------------------------------
   // Command levels raised by the link for one frame
   // ----------------------------------------------------------------
   typedef struct packed {
      logic get_status;
      logic set_ecc;
      logic ecc_bit;
      logic write_lock;
      logic other_cmd;
   } link_event_s;

   typedef enum logic [1:0] {PH_CMD, PH_ADDR, PH_DATA} phase_e;

endpackage : nand_status_pkg

// ---- status_link.sv ----
`timescale 1ns/10ps
`include "nand_status_defs.svh"

// Serial-clock side: decodes the command and address bytes, raises
// command levels for the core and shifts the status byte out.
module status_link
   import nand_status_pkg::*;
(
   input  wire logic           i_sclk,
   input  wire logic           i_cs_b,
   input  wire logic           i_mosi,
   input  wire logic           i_req_tgl,
   input  wire device_status_s i_snapshot,
   output logic                o_ack_tgl,
   output link_event_s         o_events,
   output logic                o_miso,
   output logic                o_miso_oe
);

   // ----------------------------------------------------------------
   // Byte framing
   // ----------------------------------------------------------------
   logic [2:0]     bit_r;
   phase_e         phase_r;
   logic [7:0]     shin_r;
   logic [7:0]     cmd_r;
   logic           cfg_sel_r;
   logic           status_sel_r;
   logic [1:0]     req_sync_r;
   device_status_s held_r;
   logic [7:0]     shout_r;

   // Decodes of the byte completing at this edge.
   wire [7:0] byte_in  = {shin_r[6:0], i_mosi};
   wire       byte_end = (bit_r == `BIT_LAST);
   wire       is_get   = (cmd_r == `CMD_GET_FEATURE);
   wire       is_set   = (cmd_r == `CMD_SET_FEATURE);
   wire       new_get  = (byte_in == `CMD_GET_FEATURE);
   wire       new_set  = (byte_in == `CMD_SET_FEATURE);
   wire       new_lock = (byte_in == `CMD_WRITE_LOCK);
   wire       addr_end = byte_end && (phase_r == PH_ADDR);
   wire       hit_sts  = addr_end && is_get && (byte_in == `FEAT_STATUS);
   wire       hit_cfg  = addr_end && is_set && (byte_in == `FEAT_CONFIG);
   wire       in_data  = (phase_r == PH_DATA);
   wire       reload   = byte_end && (hit_sts || (in_data && status_sel_r));
   // The snapshot is taken only after the command byte, which leaves
   // the core ample time to settle it after chip select falls.
   wire       fetch    = (phase_r != PH_CMD) && (req_sync_r[1] != o_ack_tgl);

   // Chip select high ends the frame and clears all link state.
   always_ff @(posedge i_sclk or posedge i_cs_b) begin
      if (i_cs_b) begin
         bit_r   <= `BIT_FIRST;
         phase_r <= PH_CMD;
         shin_r  <= 8'h00;
      end else begin
         bit_r  <= bit_r + 3'h1;
         shin_r <= byte_in;
         if (byte_end) begin
            case (phase_r)
               PH_CMD:  phase_r <= PH_ADDR;
               PH_ADDR: phase_r <= PH_DATA;
               PH_DATA: phase_r <= PH_DATA;
               default: phase_r <= PH_CMD;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Command decode and levels to the core
   // ----------------------------------------------------------------
   always_ff @(posedge i_sclk or posedge i_cs_b) begin
      if (i_cs_b) begin
         cmd_r        <= 8'h00;
         cfg_sel_r    <= 1'b0;
         status_sel_r <= 1'b0;
         o_events     <= '0;
      end else begin
         if (byte_end && (phase_r == PH_CMD)) begin
            cmd_r <= byte_in;
            if (new_lock) begin
               o_events.write_lock <= 1'b1;
            end else if (!new_get && !new_set) begin
               o_events.other_cmd <= 1'b1;
            end
         end
         if (hit_sts) begin
            status_sel_r        <= 1'b1;
            o_events.get_status <= 1'b1;
         end else if (addr_end) begin
            o_events.other_cmd <= 1'b1;
         end
         if (hit_cfg) begin
            cfg_sel_r <= 1'b1;
         end
         // The enable bit is held four edges before its strobe rises.
         if (in_data && cfg_sel_r && (bit_r == `CFG_ECC_SLOT)) begin
            o_events.ecc_bit <= i_mosi;
         end
         if (in_data && cfg_sel_r && byte_end) begin
            o_events.set_ecc <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Snapshot handshake and status shifter
   // ----------------------------------------------------------------
   always_ff @(posedge i_sclk or posedge i_cs_b) begin
      if (i_cs_b) begin
         req_sync_r <= 2'h0;
         o_ack_tgl  <= 1'b0;
         held_r     <= device_status_s'(`STATUS_RST);
         shout_r    <= 8'h00;
      end else begin
         req_sync_r <= {req_sync_r[0], i_req_tgl};
         if (fetch) begin
            held_r    <= i_snapshot;
            o_ack_tgl <= req_sync_r[1];
         end
         // From the status address on, each byte boundary repeats the newest status, MSB first.
         if (reload) begin
            shout_r <= held_r;
         end else begin
            shout_r <= {shout_r[6:0], 1'b0};
         end
      end
   end

   // Data changes on the falling edge so the host samples it on the rise.
   always_ff @(negedge i_sclk or posedge i_cs_b) begin
      if (i_cs_b) begin
         o_miso    <= 1'b0;
         o_miso_oe <= 1'b0;
      end else begin
         o_miso    <= shout_r[7];
         o_miso_oe <= in_data && status_sel_r;
      end
   end

endmodule : status_link

// ---- nand_status_register.sv ----
`timescale 1ns/10ps
`include "nand_status_defs.svh"

// Functional notes
// - Get-feature 0Fh at address C0h puts the status byte on the data pin.
// - Status read mode persists until the next valid command arrives.
// - Bit 0 is one while read, program, erase or reset runs.
// - Bit 1 mirrors the write latch; only then are program and erase taken.
// - Write-lock 04h or any program or erase completion clears the latch.
// - Bit 2 sets on erase failure, invalid address or protected area.
// - Reset command or start of block erase clears the erase failure bit.
// - Bit 3 sets on program failure, invalid address or protected area.
// - Reset command or program execute clears the program failure bit.
// - Bits 5:4 hold 00 clean, 01 corrected, 10 uncorrected; 11 reserved.
// - Reset command or read start clears the field; read end loads it.
// - After power-on the field shows the boot page load outcome.
// - Bit 6 is one while the cache is busy in sequential cached reads.
// - Bit 7 reserved; bit 6 also reserved on the higher-density part.
// - Set-feature at B0h writes bit 4 to turn internal ECC off or on.
module nand_status_register
   import nand_status_pkg::*;
#(
   parameter bit HIGH_DENSITY = 1'b0
)(
   input  wire logic           i_clk,
   input  wire logic           i_rst_b,
   input  wire logic           i_sclk,
   input  wire logic           i_cs_b,
   input  wire logic           i_mosi,
   input  wire logic           i_op_busy,
   input  wire logic           i_cache_busy,
   input  wire logic           i_write_enable,
   input  wire logic           i_op_request,
   input  wire logic           i_erase_start,
   input  wire logic           i_erase_done,
   input  wire logic           i_erase_fault,
   input  wire logic           i_prog_start,
   input  wire logic           i_prog_done,
   input  wire logic           i_prog_fault,
   input  wire logic           i_read_start,
   input  wire logic           i_read_done,
   input  wire logic [1:0]     i_ecc_outcome,
   input  wire logic           i_reset_cmd,
   output logic                o_miso,
   output logic                o_miso_oe,
   output device_status_s      o_device_status,
   output logic                o_op_accept,
   output logic                o_ecc_enable,
   output logic                o_status_mode
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // The reserved code never reaches the register: an engine that
   // reports it is treated as an uncorrectable read.
   function automatic logic [1:0] ecc_code(input logic [1:0] raw);
      ecc_code = (raw == `ECC_RSVD) ? `ECC_LOST : raw;
   endfunction : ecc_code

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   device_status_s sts_r;
   device_status_s sts_nxt;
   device_status_s snap_r;
   logic           req_r;
   logic           link_ack;
   logic           ack_s1_r;
   logic           ack_s2_r;
   logic           cs_s1_r;
   logic           cs_s2_r;
   link_event_s    link_evt;
   link_event_s    evt_s1_r;
   link_event_s    evt_s2_r;
   link_event_s    evt_s3_r;

   assign o_device_status = sts_r;

   // ----------------------------------------------------------------
   // Link side on the serial clock
   // ----------------------------------------------------------------
   status_link u_link (
      .i_sclk     (i_sclk),
      .i_cs_b     (i_cs_b),
      .i_mosi     (i_mosi),
      .i_req_tgl  (req_r),
      .i_snapshot (snap_r),
      .o_ack_tgl  (link_ack),
      .o_events   (link_evt),
      .o_miso     (o_miso),
      .o_miso_oe  (o_miso_oe)
   );

   // ----------------------------------------------------------------
   // Crossings into the core clock
   // ----------------------------------------------------------------
   // Each event is a level held until its frame ends, so a plain
   // two-stage synchroniser per bit is safe; a third stage finds the rise.
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         cs_s1_r  <= 1'b1;
         cs_s2_r  <= 1'b1;
         ack_s1_r <= 1'b0;
         ack_s2_r <= 1'b0;
         evt_s1_r <= '0;
         evt_s2_r <= '0;
         evt_s3_r <= '0;
      end else begin
         cs_s1_r  <= i_cs_b;
         cs_s2_r  <= cs_s1_r;
         ack_s1_r <= link_ack;
         ack_s2_r <= ack_s1_r;
         evt_s1_r <= link_evt;
         evt_s2_r <= evt_s1_r;
         evt_s3_r <= evt_s2_r;
      end
   end

   // Rising edges of the frame levels, one core cycle each.
   wire link_event_s evt_rise = link_event_s'(evt_s2_r & ~evt_s3_r);
   wire              lock_evt = evt_rise.write_lock;
   wire              link_idle = cs_s2_r;
   wire              pub_free  = (req_r == ack_s2_r);
   wire              pub_now   = link_idle || (pub_free && (snap_r != sts_r));

   // ----------------------------------------------------------------
   // Status bit set and clear terms
   // ----------------------------------------------------------------
   // Where a set and a clear meet in one cycle the set wins, so no
   // failure report or latch request is ever lost.
   wire latch_set = i_write_enable;
   wire latch_clr = lock_evt || i_prog_done || i_erase_done;
   wire erase_set = i_erase_done && i_erase_fault;
   wire erase_clr = i_reset_cmd || i_erase_start;
   wire prog_set  = i_prog_done && i_prog_fault;
   wire prog_clr  = i_reset_cmd || i_prog_start;
   wire ecc_clr   = i_reset_cmd || i_read_start;
   wire cache_bit = i_cache_busy && !HIGH_DENSITY;
   wire mode_set  = evt_rise.get_status;
   wire mode_clr  = evt_rise.other_cmd || lock_evt;

   always_comb begin
      sts_nxt = sts_r;
      sts_nxt.operation_active_flag = i_op_busy;
      if (latch_set) begin
         sts_nxt.write_latch_flag = 1'b1;
      end else if (latch_clr) begin
         sts_nxt.write_latch_flag = 1'b0;
      end
      if (erase_set) begin
         sts_nxt.erase_failure_flag = 1'b1;
      end else if (erase_clr) begin
         sts_nxt.erase_failure_flag = 1'b0;
      end
      if (prog_set) begin
         sts_nxt.program_failure_flag = 1'b1;
      end else if (prog_clr) begin
         sts_nxt.program_failure_flag = 1'b0;
      end
      // The boot page load reports through the same read-done strobe.
      if (i_read_done) begin
         {sts_nxt.correction_result_high,
          sts_nxt.correction_result_low} = ecc_code(i_ecc_outcome);
      end else if (ecc_clr) begin
         {sts_nxt.correction_result_high,
          sts_nxt.correction_result_low} = `ECC_CLEAN;
      end
      sts_nxt.cache_transfer_busy_flag = cache_bit;
      sts_nxt.reserved = 1'b0;
   end

   // ----------------------------------------------------------------
   // Status register and control outputs
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         sts_r         <= device_status_s'(`STATUS_RST);
         o_op_accept   <= 1'b0;
         o_ecc_enable  <= `ECC_EN_RST;
         o_status_mode <= 1'b0;
      end else begin
         sts_r       <= sts_nxt;
         o_op_accept <= i_op_request && sts_r.write_latch_flag;
         if (evt_rise.set_ecc) begin
            o_ecc_enable <= evt_s2_r.ecc_bit;
         end
         if (mode_set) begin
            o_status_mode <= 1'b1;
         end else if (mode_clr) begin
            o_status_mode <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Snapshot publication to the link
   // ----------------------------------------------------------------
   // While the link is idle the snapshot follows the status freely and
   // the request is parked high, so every frame starts with a fetch pending.
   // Inside a frame a new word goes out only after the last was taken,
   // which keeps the word stable while the link samples it.
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         snap_r <= device_status_s'(`STATUS_RST);
         req_r  <= 1'b0;
      end else if (pub_now) begin
         snap_r <= sts_r;
         req_r  <= link_idle ? 1'b1 : ~req_r;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);

   busy_track_a: assert property (
      i_op_busy |=> sts_r.operation_active_flag ##1
      (sts_r.operation_active_flag == $past(i_op_busy)))
      else $error("busy bit does not follow the operation");

   accept_gate_a: assert property (
      (i_op_request && !sts_r.write_latch_flag) |=> !o_op_accept)
      else $error("operation accepted without write latch");

   latch_clear_a: assert property (
      (latch_clr && !latch_set) |=> !sts_r.write_latch_flag)
      else $error("write latch not cleared");

   erase_fail_a: assert property (
      erase_set |=> sts_r.erase_failure_flag[*2] or
      (sts_r.erase_failure_flag ##1 $past(erase_clr)))
      else $error("erase failure not flagged");

   erase_clear_a: assert property (
      (erase_clr && !erase_set) |=> !sts_r.erase_failure_flag)
      else $error("erase failure not cleared");

   prog_fail_a: assert property (
      prog_set |=> sts_r.program_failure_flag)
      else $error("program failure not flagged");

   prog_clear_a: assert property (
      (prog_clr && !prog_set) |=> !sts_r.program_failure_flag)
      else $error("program failure not cleared");

   ecc_load_a: assert property (
      i_read_done |=> ({sts_r.correction_result_high,
      sts_r.correction_result_low} == ecc_code($past(i_ecc_outcome))))
      else $error("correction field not loaded at read end");

   ecc_clear_a: assert property (
      (ecc_clr && !i_read_done) |=> ({sts_r.correction_result_high,
      sts_r.correction_result_low} == `ECC_CLEAN))
      else $error("correction field not cleared");

   ecc_code_a: assert property (
      {sts_r.correction_result_high, sts_r.correction_result_low} != `ECC_RSVD)
      else $error("reserved correction code stored");

   cache_bit_a: assert property (
      (i_cache_busy && !HIGH_DENSITY) |=> sts_r.cache_transfer_busy_flag)
      else $error("cache busy not shown");

   reserved_a: assert property (
      !sts_r.reserved && !(HIGH_DENSITY && sts_r.cache_transfer_busy_flag))
      else $error("reserved status bit set");

   mode_hold_a: assert property (
      (o_status_mode && !mode_clr) |=> o_status_mode)
      else $error("status mode dropped without a command");

   ecc_cfg_a: assert property (
      evt_rise.set_ecc |=> (o_ecc_enable == $past(evt_s2_r.ecc_bit)))
      else $error("ECC enable not written");

   snap_hold_a: assert property (
      (!link_idle && !pub_free) |=> $stable(snap_r))
      else $error("snapshot changed while link was fetching");

   busy_ready_a: assert property (
      !i_op_busy |=> !sts_r.operation_active_flag)
      else $error("busy bit stuck after the operation ended");

   latch_set_a: assert property (
      latch_set |=> sts_r.write_latch_flag)
      else $error("write latch not set");

   accept_grant_a: assert property (
      (i_op_request && sts_r.write_latch_flag) |=> o_op_accept)
      else $error("request refused although write latch was set");

   mode_enter_a: assert property (
      mode_set |=> o_status_mode)
      else $error("status mode not entered");

   mode_leave_a: assert property (
      (mode_clr && !mode_set) |=> !o_status_mode)
      else $error("status mode kept after another command");

endmodule : nand_status_register

// ---- spi_host_model.sv ----
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Serial host: mode 0, clock runs only inside a frame
// ----------------------------------------------------------------
module spi_host_model (
   output logic      o_sclk,
   output logic      o_cs_b,
   output logic      o_mosi,
   input  wire logic i_miso,
   input  wire logic i_miso_oe
);
   // The clock idles low and chip select idles high between frames.
   initial begin
      o_sclk = 1'b0;
      o_cs_b = 1'b1;
      o_mosi = 1'b0;
   end

   // Sends nb bytes, MSB first, and gathers the last two data bytes.
   task automatic xfer(input logic [7:0] cmd, adr, dat, input int nb,
                       output logic [15:0] rx, output logic oe_seen);
      logic [7:0] b;
      rx = 16'h0000;
      oe_seen = 1'b0;
      #7 o_cs_b = 1'b0;
      for (int k = 0; k < nb; k++) begin
         b = (k == 0) ? cmd : (k == 1) ? adr : dat;
         for (int j = 7; j >= 0; j--) begin
            o_mosi = b[j];
            #16 o_sclk = 1'b1;
            if (k > 1) begin
               rx = {rx[14:0], i_miso};
               oe_seen = oe_seen | i_miso_oe;
            end
            #16 o_sclk = 1'b0;
         end
      end
      // The released data line flips so a stale level is never mistaken for data.
      #16 o_cs_b = 1'b1;
      o_mosi = ~o_mosi;
      #150;
   endtask : xfer
endmodule : spi_host_model

// ---- testbench.sv ----
`timescale 1ns/10ps

module testbench;
   import nand_status_pkg::*;
   localparam logic [10:0] WEN = 11'h001, OPR = 11'h002, ERS = 11'h004, ERD = 11'h008;
   localparam logic [10:0] ERF = 11'h010, PGS = 11'h020, PGD = 11'h040, PGF = 11'h080;
   localparam logic [10:0] RDS = 11'h100, RDD = 11'h200, RST = 11'h400;
   logic           i_clk = 1'b0;
   logic           i_rst_b = 1'b0;
   logic           op_busy = 1'b0;
   logic           cache_busy = 1'b0;
   logic [10:0]    st = 11'h000;
   logic [1:0]     ecc = 2'h0;
   logic           sclk, cs_b, mosi, miso, miso_oe, op_accept, ecc_en, smode, oe;
   logic [15:0]    rx;
   device_status_s sts;
   int             fails = 0;
   int             comparisons = 0;

   // ----------------------------------------------------------------
   // Clock, host model and design
   // ----------------------------------------------------------------
   always #12.5 i_clk = ~i_clk;

   spi_host_model spi_host_model_i (.o_sclk(sclk), .o_cs_b(cs_b), .o_mosi(mosi),
      .i_miso(miso), .i_miso_oe(miso_oe));

   nand_status_register nand_status_register_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
      .i_sclk(sclk), .i_cs_b(cs_b), .i_mosi(mosi), .i_op_busy(op_busy),
      .i_cache_busy(cache_busy), .i_write_enable(st[0]), .i_op_request(st[1]),
      .i_erase_start(st[2]), .i_erase_done(st[3]), .i_erase_fault(st[4]),
      .i_prog_start(st[5]), .i_prog_done(st[6]), .i_prog_fault(st[7]),
      .i_read_start(st[8]), .i_read_done(st[9]), .i_ecc_outcome(ecc),
      .i_reset_cmd(st[10]), .o_miso(miso), .o_miso_oe(miso_oe),
      .o_device_status(sts), .o_op_accept(op_accept), .o_ecc_enable(ecc_en),
      .o_status_mode(smode));

   // ----------------------------------------------------------------
   // Shared helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] got, exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask : chk

   // One-cycle strobe; results are looked at just after the taking edge.
   task automatic pulse(input logic [10:0] m, input logic [1:0] e);
      @(posedge i_clk);
      st <= m;
      ecc <= e;
      @(posedge i_clk);
      st <= 11'h000;
      #1;
   endtask : pulse

   task automatic report_and_stop();
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      chk(sts, 8'h00, "status after reset");
      chk(8'(ecc_en), 8'h01, "ecc enable after reset");
      chk(8'(smode), 8'h00, "status mode after reset");
      pulse(RDD, 2'h1);
      chk(sts, 8'h10, "boot page outcome");
      $display("test reset done");
   endtask : t_reset

   task automatic t_levels();
      pulse(RST, 2'h0);
      chk(sts, 8'h00, "reset command clears field");
      @(posedge i_clk);
      op_busy <= 1'b1;
      cache_busy <= 1'b1;
      repeat (2) @(posedge i_clk);
      #1 chk(sts, 8'h41, "busy and cache busy");
      @(posedge i_clk);
      op_busy <= 1'b0;
      cache_busy <= 1'b0;
      repeat (2) @(posedge i_clk);
      #1 chk(sts, 8'h00, "ready");
      $display("test levels done");
   endtask : t_levels

   task automatic t_latch();
      pulse(OPR, 2'h0);
      chk(8'(op_accept), 8'h00, "request refused without latch");
      pulse(WEN, 2'h0);
      chk(sts, 8'h02, "latch set");
      pulse(OPR, 2'h0);
      chk(8'(op_accept), 8'h01, "request accepted");
      pulse(PGD, 2'h0);
      chk(sts, 8'h00, "program end clears latch");
      pulse(WEN, 2'h0);
      pulse(ERD, 2'h0);
      chk(sts, 8'h00, "erase end clears latch");
      pulse(WEN, 2'h0);
      spi_host_model_i.xfer(8'h04, 8'h00, 8'h00, 1, rx, oe);
      repeat (4) @(posedge i_clk);
      #1 chk(sts, 8'h00, "write lock clears latch");
      $display("test latch done");
   endtask : t_latch

   task automatic t_fail();
      pulse(ERD | ERF, 2'h0);
      chk(sts, 8'h04, "erase failure");
      pulse(ERS, 2'h0);
      chk(sts, 8'h00, "erase start clears");
      pulse(ERD | ERF, 2'h0);
      pulse(RST, 2'h0);
      chk(sts, 8'h00, "reset clears erase failure");
      pulse(PGD | PGF, 2'h0);
      chk(sts, 8'h08, "program failure");
      pulse(PGS, 2'h0);
      chk(sts, 8'h00, "program execute clears");
      pulse(PGD | PGF, 2'h0);
      pulse(RST, 2'h0);
      chk(sts, 8'h00, "reset clears program failure");
      $display("test fail done");
   endtask : t_fail

   // Every outcome code, each followed by a read start that clears it.
   task automatic t_ecc();
      for (int c = 0; c < 4; c++) begin
         pulse(RDD, 2'(c));
         chk(sts, (c == 3) ? 8'h20 : 8'(c << 4), "correction outcome");
         pulse(RDS, 2'h0);
         chk(sts, 8'h00, "read start clears");
      end
      $display("test ecc done");
   endtask : t_ecc

   task automatic t_serial();
      pulse(WEN, 2'h0);
      pulse(PGD | PGF, 2'h0);
      pulse(WEN, 2'h0);
      pulse(RDD, 2'h1);
      repeat (10) @(posedge i_clk);
      spi_host_model_i.xfer(8'h0f, 8'hc0, 8'h00, 4, rx, oe);
      chk(rx[15:8], 8'h1a, "first status byte");
      chk(rx[7:0], 8'h1a, "repeated status byte");
      chk(8'(oe), 8'h01, "data driven");
      chk(8'(smode), 8'h01, "status mode entered");
      spi_host_model_i.xfer(8'h0f, 8'hb0, 8'h00, 3, rx, oe);
      chk(8'(oe), 8'h00, "no data at other address");
      chk(8'(smode), 8'h00, "next command leaves status mode");
      // Set-feature at B0h with bit 4 clear turns correction off, then with bit 4 set turns it on.
      spi_host_model_i.xfer(8'h1f, 8'hb0, 8'h00, 3, rx, oe);
      chk(8'(ecc_en), 8'h00, "correction disabled");
      spi_host_model_i.xfer(8'h1f, 8'hb0, 8'h10, 3, rx, oe);
      chk(8'(ecc_en), 8'h01, "correction enabled");
      $display("test serial done");
   endtask : t_serial

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge i_clk);
      i_rst_b <= 1'b1;
      @(posedge i_clk);
      #1;
      t_reset();
      t_levels();
      t_latch();
      t_fail();
      t_ecc();
      t_serial();
      report_and_stop();
   end

   // Generous bound: the whole sequence needs well under 20 us.
   initial begin
      #400000;
      fails++;
      report_and_stop();
   end
endmodule : testbench
